// ===== cio_pkg.sv
// shared constants and types for the console keyboard i/o controller
package cio_pkg;

  // word geometry
  localparam int WORD_W = 16;
  localparam int KEY_W = 8;

  // clock and mechanical timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TU_PERIOD_US = 300;
  localparam int STROBE_WIDTH_US = 10;
  // longest time: round down
  localparam int TU_PERIOD_CYC = (TU_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  // least time: round up
  localparam int STROBE_WIDTH_CYC = (STROBE_WIDTH_US * 1000000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int TCNT_W = 16;
  typedef logic [TCNT_W-1:0] cio_tcnt_t;

  // control word bit positions (bits numbered 1..16)
  localparam int MECH_EN_LO = 12;
  localparam int MECH_EN_HI = 14;
  localparam int KBD_EN_BIT = 15;

  // status word bit positions
  localparam int ST_KBD_READY_BIT = 12;
  localparam int ST_OVERRUN_BIT = 14;

  // reset values
  localparam logic KBD_EN_RST = 1'b1;
  localparam logic [2:0] MECH_EN_RST = 3'h0;
  localparam logic [WORD_W:1] WORD_RST = 16'h0000;
  localparam logic [KEY_W-1:0] KEY_RST = 8'h00;

  // port address: low selects data, high selects instruction
  localparam logic ADDR_DATA = 1'b0;
  localparam logic ADDR_INSTR = 1'b1;

  // read source of the pending answer
  typedef enum logic [1:0] {
    CIO_RD_NONE = 2'b00,
    CIO_RD_STATUS = 2'b01,
    CIO_RD_DATA = 2'b10
  } cio_rdsrc_t;

endpackage

// ===== cio_kbd_if.sv
// keyboard buffer signals between controller and buffer
`timescale 1ns/1ps
interface cio_kbd_if;
  logic keyStrobe;
  logic [cio_pkg::KEY_W-1:0] keyCode;
  logic kbdEnableFlop;
  logic systemClear;
  logic dataReadN;
  logic shiftPulseOneN;
  logic shiftPulseTwoN;
  logic shiftPulseThreeN;
  logic stageOneFull;
  logic stageTwoFull;
  logic kbdOverrunN;
  logic [cio_pkg::KEY_W-1:0] stageTwoCode;
  logic [cio_pkg::KEY_W-1:0] stageThreeCode;

  modport ctrl (
    output keyStrobe, keyCode, kbdEnableFlop, systemClear, dataReadN,
    input shiftPulseOneN, shiftPulseTwoN, shiftPulseThreeN, stageOneFull,
    input stageTwoFull, kbdOverrunN, stageTwoCode, stageThreeCode
  );
  modport fifo (
    input keyStrobe, keyCode, kbdEnableFlop, systemClear, dataReadN,
    output shiftPulseOneN, shiftPulseTwoN, shiftPulseThreeN, stageOneFull,
    output stageTwoFull, kbdOverrunN, stageTwoCode, stageThreeCode
  );
endinterface

// ===== cio_kbd_fifo.sv
// three-stage keyboard character buffer with its shift control
`timescale 1ns/1ps
module cio_kbd_fifo (
  input wire logic clk_sys,
  input wire logic nrst,
  cio_kbd_if.fifo kb
);

  logic stageOneFull_r;
  logic stageTwoFull_r;
  logic [cio_pkg::KEY_W-1:0] stageOne_r;
  logic [cio_pkg::KEY_W-1:0] stageTwo_r;
  logic [cio_pkg::KEY_W-1:0] stageThree_r;
  logic stageOneShiftGate;
  logic shiftTwo;
  logic shiftThree;

  assign stageOneShiftGate = kb.keyStrobe & kb.kbdEnableFlop & ~stageOneFull_r;
  assign shiftTwo = stageOneFull_r & ~stageTwoFull_r;
  assign shiftThree = ~kb.dataReadN & stageTwoFull_r;

  assign kb.shiftPulseOneN = ~stageOneShiftGate;
  assign kb.shiftPulseTwoN = ~shiftTwo;
  assign kb.shiftPulseThreeN = ~shiftThree;
  // strobe while stage one still holds a character
  assign kb.kbdOverrunN = ~(kb.keyStrobe & kb.kbdEnableFlop & stageOneFull_r);
  assign kb.stageOneFull = stageOneFull_r;
  assign kb.stageTwoFull = stageTwoFull_r;
  assign kb.stageTwoCode = stageTwo_r;
  assign kb.stageThreeCode = stageThree_r;

  // occupancy flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stageOneFull_r <= 1'b0;
      stageTwoFull_r <= 1'b0;
    end else if (kb.systemClear) begin
      stageOneFull_r <= 1'b0;
      stageTwoFull_r <= 1'b0;
    end else begin
      // first shift sets stage one, second shift clears it
      if (stageOneShiftGate) begin
        stageOneFull_r <= 1'b1;
      end else if (shiftTwo) begin
        stageOneFull_r <= 1'b0;
      end
      // set stage two, release after readout
      if (shiftTwo) begin
        stageTwoFull_r <= 1'b1;
      end else if (shiftThree) begin
        stageTwoFull_r <= 1'b0;
      end
    end
  end

  // character data path
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stageOne_r <= cio_pkg::KEY_RST;
      stageTwo_r <= cio_pkg::KEY_RST;
      stageThree_r <= cio_pkg::KEY_RST;
    end else begin
      // capture key code on first shift
      if (stageOneShiftGate) begin
        stageOne_r <= kb.keyCode;
      end
      if (shiftTwo) begin
        stageTwo_r <= stageOne_r;
      end
      // third stage takes the character for readout
      if (shiftThree) begin
        stageThree_r <= stageTwo_r;
      end
    end
  end

endmodule

// ===== cio_ctrl.sv
// console keyboard i/o controller top: port decode, status, timing, keyboard
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - control word bits 12..15 enable mechanisms; data interrupt only once enabled
// - indicator data words accepted any time, no enable, no interrupt
// - instruction read returns the status word
// - address-status request returns status when this unit holds priority and its status interrupt is up
// - status bits 9..12 data conditions, bits 13..16 status conditions
// - timer pulse derived from shaft once every 300 us
// - transducer strobe 10 us wide every 300 us
// - timer input flop stays set while transducer output is high
// - control word bit 15 sets the keyboard enable flop
// - keyboard enabled automatically at power-up and after halt-and-clear
// - clear forces keyboard enable flop set
// - instruction write decoded from write select low and instruction select high
// - keyboard characters held in three-stage first-in first-out buffer
// - key press sets keyboard ready and data interrupt if enabled
// - clear resets stage one and stage two occupancy flops
// - qualified strobe with stage one empty makes first shift, sets stage one
// - key code captured into stage one on first shift
// - stage one full, stage two empty: advance, set two, clear one
// - data read with stage two full makes third shift
// - third shift places character on memory information lines
// - strobe with stage one full flags overrun, bit 14, status interrupt
module cio_ctrl #(
  parameter int TU_PERIOD_CYCLES = cio_pkg::TU_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic systemClear,
  input wire logic portInstrSel,
  input wire logic portWrite,
  input wire logic portRead,
  input wire logic [cio_pkg::WORD_W:1] memInfoIn,
  output logic [cio_pkg::WORD_W:1] memInfoOut,
  input wire logic addressStatusRequest,
  input wire logic statusPriority,
  output logic [cio_pkg::WORD_W:1] statusWordBus,
  output logic statusWordValid,
  input wire logic keyStrobe,
  input wire logic [cio_pkg::KEY_W-1:0] keyCodeBit,
  input wire logic timerUnitInput,
  output logic transducerStrobe,
  output logic timerUnitPulse,
  output logic timerInputFf,
  output logic dataInterrupt,
  output logic statusInterrupt,
  output logic kbdEnable,
  output logic [2:0] mechEnable,
  output logic [cio_pkg::WORD_W:1] indicatorWord,
  output logic indicatorLoad
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  cio_kbd_if kb ();

  logic portWriteSelN;
  logic portReadSelN;
  logic instrWriteDecode;
  logic instrWriteClockN;
  logic dataWrite;
  logic instrRead;
  logic dataReadN;
  logic clearN;

  logic kbdEnableFlop_r;
  logic [2:0] mechEnable_r;
  logic [cio_pkg::WORD_W:1] indicator_r;
  logic indicatorLoad_r;
  logic overrun_r;
  logic kbdReady;
  logic [cio_pkg::WORD_W:1] statusWord;

  cio_pkg::cio_rdsrc_t readSrc_r;
  logic [cio_pkg::WORD_W:1] memInfoOut_r;
  logic [cio_pkg::WORD_W:1] statusWordBus_r;
  logic statusWordValid_r;

  cio_pkg::cio_tcnt_t periodCnt_r;
  logic transducerStrobe_r;
  logic timerInputFf_r;
  logic timerUnitPulse_r;
  logic periodEnd;
  logic strobeEnd;

  //////////////////////////////////////////////////////////////////////////////
  // helper functions

  // place a key code into the low byte of a port word
  function automatic logic [cio_pkg::WORD_W:1] keyWord(
    input logic [cio_pkg::KEY_W-1:0] code
  );
    logic [cio_pkg::WORD_W:1] w;
    w = cio_pkg::WORD_RST;
    w[cio_pkg::KEY_W:1] = code;
    return w;
  endfunction

  // cycle count parameter cut to counter width
  function automatic cio_pkg::cio_tcnt_t tcnt(input int value);
    return cio_pkg::cio_tcnt_t'(value);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // port decode

  // active-low selects made from the active-high port strobes
  assign portWriteSelN = ~portWrite;
  assign portReadSelN = ~portRead;
  assign clearN = ~systemClear;

  assign instrWriteDecode = ~portWriteSelN & (portInstrSel == cio_pkg::ADDR_INSTR);
  // load clock qualified by the system clock edge
  assign instrWriteClockN = ~instrWriteDecode;

  // data write carries an indicator word
  assign dataWrite = ~portWriteSelN & (portInstrSel == cio_pkg::ADDR_DATA);
  // read with instruction select returns status
  assign instrRead = ~portReadSelN & (portInstrSel == cio_pkg::ADDR_INSTR);
  // data read is a read without instruction select
  assign dataReadN = ~(~portReadSelN & (portInstrSel == cio_pkg::ADDR_DATA));

  //////////////////////////////////////////////////////////////////////////////
  // control word

  // keyboard enable flop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      kbdEnableFlop_r <= cio_pkg::KBD_EN_RST;
    end else if (!clearN) begin
      kbdEnableFlop_r <= 1'b1;
    // control word bit 15 sets or drops the enable
    end else if (!instrWriteClockN) begin
      kbdEnableFlop_r <= memInfoIn[cio_pkg::KBD_EN_BIT];
    end
  end

  // enables for the other mechanisms
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mechEnable_r <= cio_pkg::MECH_EN_RST;
    end else if (systemClear) begin
      mechEnable_r <= cio_pkg::MECH_EN_RST;
    // bits 12..14 latched from the control word
    end else if (!instrWriteClockN) begin
      mechEnable_r <= memInfoIn[cio_pkg::MECH_EN_HI:cio_pkg::MECH_EN_LO];
    end
  end

  assign kbdEnable = kbdEnableFlop_r;
  assign mechEnable = mechEnable_r;

  //////////////////////////////////////////////////////////////////////////////
  // indicator section

  // indicator word register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      indicator_r <= cio_pkg::WORD_RST;
      indicatorLoad_r <= 1'b0;
    end else begin
      // any data write is taken, no enable needed
      indicatorLoad_r <= dataWrite;
      if (dataWrite) begin
        indicator_r <= memInfoIn;
      end
    end
  end

  assign indicatorWord = indicator_r;
  assign indicatorLoad = indicatorLoad_r;

  //////////////////////////////////////////////////////////////////////////////
  // keyboard buffer

  // connections to the buffer
  assign kb.keyStrobe = keyStrobe;
  assign kb.keyCode = keyCodeBit;
  assign kb.kbdEnableFlop = kbdEnableFlop_r;
  assign kb.systemClear = systemClear;
  assign kb.dataReadN = dataReadN;

  cio_kbd_fifo u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .kb(kb)
  );

  assign kbdReady = kb.stageOneFull | kb.stageTwoFull;

  // overrun flag, set wins over the clear by status read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      overrun_r <= 1'b0;
    // strobe into a full first stage
    end else if (!kb.kbdOverrunN) begin
      overrun_r <= 1'b1;
    end else if (systemClear || instrRead) begin
      overrun_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status word and interrupts

  // status word assembly
  always_comb begin
    statusWord = cio_pkg::WORD_RST;
    statusWord[cio_pkg::ST_KBD_READY_BIT] = kbdReady;
    statusWord[cio_pkg::ST_OVERRUN_BIT] = overrun_r;
  end

  // data interrupt held while a character is unread and the keyboard enable flop is set
  assign dataInterrupt = kbdReady & kbdEnableFlop_r;
  assign statusInterrupt = overrun_r;

  //////////////////////////////////////////////////////////////////////////////
  // read answers

  // which source answers the read just taken
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      readSrc_r <= cio_pkg::CIO_RD_NONE;
    end else if (instrRead) begin
      readSrc_r <= cio_pkg::CIO_RD_STATUS;
    end else if (!dataReadN) begin
      readSrc_r <= cio_pkg::CIO_RD_DATA;
    end else begin
      readSrc_r <= cio_pkg::CIO_RD_NONE;
    end
  end

  // memory information lines, valid only in the cycle after the read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      memInfoOut_r <= cio_pkg::WORD_RST;
    end else if (instrRead) begin
      memInfoOut_r <= statusWord;
    // third shift places the character on the lines
    end else if (!kb.shiftPulseThreeN) begin
      memInfoOut_r <= keyWord(kb.stageTwoCode);
    end else begin
      memInfoOut_r <= cio_pkg::WORD_RST;
    end
  end

  assign memInfoOut = memInfoOut_r;

  // address and status request answer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      statusWordBus_r <= cio_pkg::WORD_RST;
      statusWordValid_r <= 1'b0;
    // answer only when interrupting with top priority
    end else if (addressStatusRequest && statusPriority && statusInterrupt) begin
      statusWordBus_r <= statusWord;
      statusWordValid_r <= 1'b1;
    end else begin
      statusWordBus_r <= cio_pkg::WORD_RST;
      statusWordValid_r <= 1'b0;
    end
  end

  assign statusWordBus = statusWordBus_r;
  assign statusWordValid = statusWordValid_r;

  //////////////////////////////////////////////////////////////////////////////
  // mechanical timing

  // period end and strobe end markers
  assign periodEnd = (periodCnt_r == tcnt(TU_PERIOD_CYCLES - 1));
  assign strobeEnd = (periodCnt_r == tcnt(cio_pkg::STROBE_WIDTH_CYC - 1));

  // free-running period counter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      periodCnt_r <= '0;
    end else if (periodEnd) begin
      periodCnt_r <= '0;
    end else begin
      periodCnt_r <= periodCnt_r + tcnt(1);
    end
  end

  // transducer strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      transducerStrobe_r <= 1'b0;
    end else if (periodEnd) begin
      transducerStrobe_r <= 1'b1;
    end else if (strobeEnd) begin
      transducerStrobe_r <= 1'b0;
    end
  end

  // timer unit input flop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timerInputFf_r <= 1'b0;
    end else if (periodEnd) begin
      timerInputFf_r <= 1'b1;
    // stays set while the transducer reads high
    end else if (transducerStrobe_r && !timerUnitInput) begin
      timerInputFf_r <= 1'b0;
    end
  end

  // timer unit pulse
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timerUnitPulse_r <= 1'b0;
    end else begin
      // one pulse per 300 us at strobe end when the flag was seen
      timerUnitPulse_r <= strobeEnd & timerInputFf_r & timerUnitInput;
    end
  end

  assign transducerStrobe = transducerStrobe_r;
  assign timerInputFf = timerInputFf_r;
  assign timerUnitPulse = timerUnitPulse_r;

endmodule

// ===== cio_ctrl_monitor.sv
// assertion checker on the console keyboard controller ports
`timescale 1ns/1ps
module cio_ctrl_monitor #(
  parameter int TU_PERIOD_CYCLES = cio_pkg::TU_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic systemClear,
  input wire logic portInstrSel,
  input wire logic portWrite,
  input wire logic portRead,
  input wire logic [cio_pkg::WORD_W:1] memInfoIn,
  input wire logic [cio_pkg::WORD_W:1] memInfoOut,
  input wire logic addressStatusRequest,
  input wire logic statusPriority,
  input wire logic [cio_pkg::WORD_W:1] statusWordBus,
  input wire logic statusWordValid,
  input wire logic keyStrobe,
  input wire logic timerUnitInput,
  input wire logic transducerStrobe,
  input wire logic timerUnitPulse,
  input wire logic timerInputFf,
  input wire logic dataInterrupt,
  input wire logic statusInterrupt,
  input wire logic kbdEnable,
  input wire logic [2:0] mechEnable,
  input wire logic [cio_pkg::WORD_W:1] indicatorWord,
  input wire logic indicatorLoad
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  cio_pkg::cio_tcnt_t hiCnt_r;
  cio_pkg::cio_tcnt_t gapCnt_r;
  logic prevStrobe_r;
  logic seenRise_r;
  logic strobeRise;
  logic [cio_pkg::WORD_W:1] prevIn_r;
  ////////////////////////////////////////////////////////////
  // strobe run length and spacing of rises
  assign strobeRise = transducerStrobe & ~prevStrobe_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hiCnt_r <= '0;
      gapCnt_r <= '0;
      prevStrobe_r <= 1'h0;
      seenRise_r <= 1'h0;
    end else begin
      hiCnt_r <= transducerStrobe ? hiCnt_r + 16'h0001 : '0;
      gapCnt_r <= strobeRise ? 16'h0001 : gapCnt_r + 16'h0001;
      prevStrobe_r <= transducerStrobe;
      seenRise_r <= seenRise_r | strobeRise;
    end
  end
  // write data of the previous cycle
  always_ff @(posedge clk_sys) begin
    prevIn_r <= memInfoIn;
  end
  ////////////////////////////////////////////////////////////
  strobe_width_a: assert property (
    $fell(transducerStrobe) |-> hiCnt_r == cio_pkg::cio_tcnt_t'(cio_pkg::STROBE_WIDTH_CYC))
    else $error("strobe width wrong");
  strobe_period_a: assert property (
    strobeRise && seenRise_r |-> gapCnt_r == cio_pkg::cio_tcnt_t'(TU_PERIOD_CYCLES))
    else $error("strobe period wrong");
  timer_pulse_a: assert property (
    timerUnitPulse == ($fell(transducerStrobe) && $past(timerUnitInput) && $past(timerInputFf)))
    else $error("timer pulse wrong");
  flop_follow_a: assert property (
    transducerStrobe |=> timerInputFf == ($past(timerInputFf) && $past(timerUnitInput)))
    else $error("timer input flop wrong");
  clear_init_a: assert property (
    systemClear && !portWrite && !keyStrobe |=> kbdEnable && !dataInterrupt
      && !statusInterrupt && mechEnable == 3'h0)
    else $error("clear state wrong");
  ctrl_write_a: assert property (
    portWrite && portInstrSel && !systemClear |=> kbdEnable == prevIn_r[15]
      && mechEnable == prevIn_r[14:12])
    else $error("control write wrong");
  ind_write_a: assert property (
    portWrite && !portInstrSel |=> indicatorLoad && indicatorWord == prevIn_r)
    else $error("indicator write wrong");
  stat_read_a: assert property (
    portRead && portInstrSel && kbdEnable && !keyStrobe && !systemClear |=> memInfoOut ==
      {2'h0, $past(statusInterrupt), 1'h0, $past(dataInterrupt), 11'h000})
    else $error("status read wrong");
  read_idle_a: assert property (
    !portRead |=> memInfoOut == 16'h0000)
    else $error("read bus not idle");
  asr_answer_a: assert property (
    addressStatusRequest && statusPriority && statusInterrupt |=> statusWordValid
      && statusWordBus[14])
    else $error("asr answer missing");
  asr_quiet_a: assert property (
    !(addressStatusRequest && statusPriority && statusInterrupt) |=> !statusWordValid)
    else $error("asr answer unexpected");
  key_irq_a: assert property (
    keyStrobe && kbdEnable && !systemClear && !(portWrite && portInstrSel) |=> dataInterrupt)
    else $error("key interrupt missing");
  irq_gate_a: assert property (
    !kbdEnable |-> !dataInterrupt)
    else $error("interrupt while disabled");
  // main scenarios reached
  cover property (statusWordValid);
  cover property (timerUnitPulse);
  cover property (keyStrobe && kbdEnable && dataInterrupt);
endmodule

// ===== cio_host_model.sv
// processor device port model issuing control, data, status and asr transfers
`timescale 1ns/1ps
module cio_host_model (
  input wire logic clk_sys,
  output logic systemClear,
  output logic portInstrSel,
  output logic portWrite,
  output logic portRead,
  output logic [cio_pkg::WORD_W:1] memInfoIn,
  output logic addressStatusRequest,
  output logic statusPriority,
  input wire logic [cio_pkg::WORD_W:1] memInfoOut,
  input wire logic [cio_pkg::WORD_W:1] statusWordBus,
  input wire logic statusWordValid
);
  // idle port at time zero
  initial begin
    systemClear = 1'h0;
    portInstrSel = 1'h0;
    portWrite = 1'h0;
    portRead = 1'h0;
    memInfoIn = 16'h0000;
    addressStatusRequest = 1'h0;
    statusPriority = 1'h0;
  end
  task automatic wr(input logic instr, input logic [cio_pkg::WORD_W:1] d);
    @(posedge clk_sys);
    portWrite <= 1'h1;
    portInstrSel <= instr;
    memInfoIn <= d;
    @(posedge clk_sys);
    portWrite <= 1'h0;
    memInfoIn <= ~d;
  endtask
  // read strobe, answer taken one cycle later
  task automatic rd(input logic instr, output logic [cio_pkg::WORD_W:1] d);
    @(posedge clk_sys);
    portRead <= 1'h1;
    portInstrSel <= instr;
    @(posedge clk_sys);
    portRead <= 1'h0;
    @(posedge clk_sys);
    d = memInfoOut;
  endtask
  // address and status request
  task automatic address_status_request(input logic prio, output logic v, output logic [cio_pkg::WORD_W:1] d);
    @(posedge clk_sys);
    addressStatusRequest <= 1'h1;
    statusPriority <= prio;
    @(posedge clk_sys);
    addressStatusRequest <= 1'h0;
    @(posedge clk_sys);
    v = statusWordValid;
    d = statusWordBus;
  endtask
  // one-cycle halt clear
  task automatic clr();
    @(posedge clk_sys);
    systemClear <= 1'h1;
    @(posedge clk_sys);
    systemClear <= 1'h0;
  endtask
endmodule

// ===== cio_ctrl_tb.sv
// self-checking bench for the console keyboard controller
`timescale 1ns/1ps
module cio_ctrl_tb;
  localparam int TU_P = 2100;
  localparam int STRB = cio_pkg::STROBE_WIDTH_CYC;
  localparam logic INS = cio_pkg::ADDR_INSTR;
  localparam logic DAT = cio_pkg::ADDR_DATA;
  logic clk_sys, nrst, systemClear, portInstrSel, portWrite, portRead, v;
  logic addressStatusRequest, statusPriority, statusWordValid, keyStrobe, timerUnitInput;
  logic transducerStrobe, timerUnitPulse, timerInputFf, dataInterrupt, statusInterrupt;
  logic kbdEnable, indicatorLoad;
  logic [cio_pkg::WORD_W:1] memInfoIn, memInfoOut, statusWordBus, indicatorWord, w;
  logic [cio_pkg::KEY_W-1:0] keyCodeBit;
  logic [2:0] mechEnable;
  int nMismatch = 0;
  int cmpCount = 0;

  cio_ctrl #(.TU_PERIOD_CYCLES(TU_P)) dut (
    .clk_sys, .nrst, .systemClear, .portInstrSel, .portWrite, .portRead, .memInfoIn,
    .memInfoOut, .addressStatusRequest, .statusPriority, .statusWordBus, .statusWordValid,
    .keyStrobe, .keyCodeBit, .timerUnitInput, .transducerStrobe, .timerUnitPulse,
    .timerInputFf, .dataInterrupt, .statusInterrupt, .kbdEnable, .mechEnable,
    .indicatorWord, .indicatorLoad
  );
  cio_host_model host (
    .clk_sys, .systemClear, .portInstrSel, .portWrite, .portRead, .memInfoIn,
    .addressStatusRequest, .statusPriority, .memInfoOut, .statusWordBus, .statusWordValid
  );
  ////////////////////////////////////////////////////////////
  // host supplied clock
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // compare helpers
  task automatic chk_bit(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [16:1] got, input logic [16:1] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one key press, code line inverted afterwards
  task automatic press(input logic [7:0] code);
    @(posedge clk_sys);
    keyStrobe <= 1'h1;
    keyCodeBit <= code;
    @(posedge clk_sys);
    keyStrobe <= 1'h0;
    keyCodeBit <= ~code;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    #1 chk_bit(kbdEnable, 1'h1);
    chk_bit(statusInterrupt, 1'h0);
    chk_bit(dataInterrupt, 1'h0);
    chk_word({13'h0000, mechEnable}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 3; i++) begin
      host.wr(INS, 16'h0800 << i);
      #1 chk_word({13'h0000, mechEnable}, 16'h0001 << i);
      chk_bit(kbdEnable, 1'h0);
    end
    press(8'h55);
    #1 chk_bit(dataInterrupt, 1'h0);
    host.rd(DAT, w);
    chk_word(w, 16'h0000);
    host.wr(INS, 16'h4000);
    #1 chk_bit(kbdEnable, 1'h1);
    chk_word({13'h0000, mechEnable}, 16'h0000);
    $display("test control done");
  endtask
  task automatic t_ind();
    host.wr(DAT, 16'hA5C3);
    #1 chk_bit(indicatorLoad, 1'h1);
    chk_word(indicatorWord, 16'hA5C3);
    chk_bit(dataInterrupt, 1'h0);
    $display("test indicator done");
  endtask
  task automatic t_key();
    press(8'h41);
    #1 chk_bit(dataInterrupt, 1'h1);
    host.rd(INS, w);
    chk_word(w, 16'h0800);
    host.rd(DAT, w);
    chk_word(w, 16'h0041);
    chk_bit(dataInterrupt, 1'h0);
    host.rd(DAT, w);
    chk_word(w, 16'h0000);
    $display("test key done");
  endtask
  task automatic t_over();
    press(8'h31);
    press(8'h32);
    #1 chk_bit(statusInterrupt, 1'h0);
    press(8'h33);
    #1 chk_bit(statusInterrupt, 1'h1);
    host.address_status_request(1'h0, v, w);
    chk_bit(v, 1'h0);
    host.address_status_request(1'h1, v, w);
    chk_bit(v, 1'h1);
    chk_word(w, 16'h2800);
    host.rd(INS, w);
    chk_word(w, 16'h2800);
    chk_bit(statusInterrupt, 1'h0);
    host.rd(DAT, w);
    chk_word(w, 16'h0031);
    host.rd(DAT, w);
    chk_word(w, 16'h0032);
    host.rd(DAT, w);
    chk_word(w, 16'h0000);
    chk_bit(dataInterrupt, 1'h0);
    $display("test overrun done");
  endtask
  task automatic t_clear();
    press(8'h77);
    host.wr(INS, 16'h0800);
    #1 chk_bit(dataInterrupt, 1'h0);
    host.clr();
    #1 chk_bit(kbdEnable, 1'h1);
    chk_word({13'h0000, mechEnable}, 16'h0000);
    chk_bit(dataInterrupt, 1'h0);
    host.rd(DAT, w);
    chk_word(w, 16'h0000);
    $display("test clear done");
  endtask
  task automatic t_timing();
    int hi;
    int k;
    int pul[2];
    logic ff[2];
    hi = 0;
    k = 0;
    pul = '{0, 0};
    @(posedge clk_sys);
    timerUnitInput <= 1'h1;
    while (transducerStrobe !== 1'h1 && k < 2 * TU_P) begin
      @(posedge clk_sys);
      k++;
    end
    // flag present one period, then absent one period
    for (int i = 0; i < 2 * TU_P; i++) begin
      if (i == TU_P) begin
        timerUnitInput <= 1'h0;
      end
      hi += int'(i < TU_P && transducerStrobe === 1'h1);
      pul[i / TU_P] += int'(timerUnitPulse === 1'h1);
      if (i % TU_P == STRB + 4) begin
        ff[i / TU_P] = timerInputFf;
      end
      @(posedge clk_sys);
    end
    chk_word(16'(hi), 16'(STRB));
    chk_word(16'(pul[0]), 16'h0001);
    chk_word(16'(pul[1]), 16'h0000);
    chk_bit(ff[0], 1'h1);
    chk_bit(ff[1], 1'h0);
    $display("test timing done");
  endtask
  ////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    nMismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  // reset then test sequence
  initial begin
    nrst = 1'h0;
    keyStrobe = 1'h0;
    keyCodeBit = 8'h00;
    timerUnitInput = 1'h0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'h1;
    t_reset();
    t_ctrl();
    t_ind();
    t_key();
    t_over();
    t_clear();
    t_timing();
    tally_and_finish();
  end
endmodule

bind cio_ctrl cio_ctrl_monitor #(.TU_PERIOD_CYCLES(TU_PERIOD_CYCLES)) mon (
  .clk_sys, .nrst, .systemClear, .portInstrSel, .portWrite, .portRead, .memInfoIn,
  .memInfoOut, .addressStatusRequest, .statusPriority, .statusWordBus, .statusWordValid,
  .keyStrobe, .timerUnitInput, .transducerStrobe, .timerUnitPulse, .timerInputFf,
  .dataInterrupt, .statusInterrupt, .kbdEnable, .mechEnable, .indicatorWord, .indicatorLoad
);
